// ==== tscc_conv_config.sv ====
// Conversion sequencer, offset correction and configuration registers
// Operation
// [RULE1] Per-remote model bit, one selects compensated
// [RULE2] Signed half-degree offset per remote, reset zero
// [RULE3] Offset added to remote raw result
// [RULE4] Standby bit six halts periodic converting
// [RULE5] Two-bit code picks conversion interval
// [RULE6] Convert enabled channels, then pad interval
// [RULE7] Disabled channels skipped, order kept
// [RULE8] Continuous shortens; other rates pad out
// [RULE9] Enable bits: remote two, remote one, local
// [RULE10] Reserved bits always read zero
// [RULE11] One-shot write in standby runs sequence
// [RULE12] Busy status bit while converting
// [RULE13] Writes to reserved bits are ignored
module tscc_conv_config #(
    parameter int CYC_PER_TICK = tscc_pkg::CYC_PER_TICK
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_wr_en,
    input  wire logic        i_rd_en,
    input  wire logic [7:0]  i_cmd,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata,
    output logic             o_conv_start,
    output logic      [1:0]  o_conv_chan,
    output logic             o_model_sel,
    input  wire logic        i_conv_done,
    input  wire logic [10:0] i_conv_raw,
    output logic             o_temp_valid,
    output logic      [1:0]  o_temp_chan,
    output logic      [10:0] o_temp_value,
    output logic             o_busy
);
    initial begin
        if (CYC_PER_TICK < 2) begin
            $error("tscc_conv_config: CYC_PER_TICK must be at least 2");
        end
    end

    localparam int TW = tscc_pkg::TICK_W;

    // Configuration state
    logic [1:0] model_q, model_d;
    logic       standby_control_q, standby_control_d;
    logic [1:0] rate_q, rate_d;
    logic [2:0] chen_q, chen_d;
    logic [7:0] off1_q, off1_d;
    logic [7:0] off2_q, off2_d;
    logic       shot_q, shot_d;
    logic [7:0] rdata_q, rdata_d;

    // Sequencer state
    tscc_pkg::tscc_seq_type st_q, st_d;
    logic [1:0]    chan_q, chan_d;
    logic [TW-1:0] ms_q, ms_d;
    logic          start_q, start_d;
    logic          seq_begin;
    logic          tick;

    // Result state
    logic          tv_q, tv_d;
    logic [1:0]    tc_q, tc_d;
    logic [10:0]   tval_q, tval_d;

    // Register writes keep only the defined fields
    always_comb begin
        model_d = model_q;
        standby_control_d  = standby_control_q;
        rate_d  = rate_q;
        chen_d  = chen_q;
        off1_d  = off1_q;
        off2_d  = off2_q;
        shot_d  = shot_q;
        if (seq_begin) begin
            shot_d = 1'b0;
        end
        if (i_wr_en) begin
            case (i_cmd)
                tscc_pkg::CMD_DIODE:   model_d = i_wdata[2:1]; // [RULE1] [RULE13]
                tscc_pkg::CMD_CONFIG:  standby_control_d = i_wdata[tscc_pkg::STANDBY_BIT]; // [RULE4]
                tscc_pkg::CMD_RATE:    rate_d = i_wdata[1:0]; // [RULE5] [RULE13]
                tscc_pkg::CMD_CHAN_EN: chen_d = i_wdata[2:0]; // [RULE9] [RULE13]
                tscc_pkg::CMD_OFF_ONE: off1_d = i_wdata; // [RULE2]
                tscc_pkg::CMD_OFF_TWO: off2_d = i_wdata; // [RULE2]
                // Data is dropped; only honoured in standby
                tscc_pkg::CMD_ONE_SHOT: shot_d = standby_control_q | shot_q; // [RULE11]
                default: ;
            endcase
        end
    end

    // Read mux; unmapped commands answer zero
    always_comb begin
        rdata_d = rdata_q;
        if (i_rd_en) begin
            case (i_cmd)
                tscc_pkg::CMD_DIODE:   rdata_d = {5'h00, model_q, 1'b0}; // [RULE10]
                tscc_pkg::CMD_CONFIG:  rdata_d = {1'b0, standby_control_q, 6'h00}; // [RULE10]
                tscc_pkg::CMD_RATE:    rdata_d = {6'h00, rate_q}; // [RULE10]
                tscc_pkg::CMD_CHAN_EN: rdata_d = {5'h00, chen_q}; // [RULE10]
                tscc_pkg::CMD_OFF_ONE: rdata_d = off1_q;
                tscc_pkg::CMD_OFF_TWO: rdata_d = off2_q;
                tscc_pkg::CMD_STATUS:  rdata_d = {o_busy, 7'h00}; // [RULE12]
                default:               rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            model_q <= tscc_pkg::RST_DIODE[2:1];
            standby_control_q  <= tscc_pkg::RST_CONFIG[tscc_pkg::STANDBY_BIT];
            rate_q  <= tscc_pkg::RST_RATE[1:0];
            chen_q  <= tscc_pkg::RST_CHAN_EN[2:0];
            off1_q  <= tscc_pkg::RST_OFFSET;
            off2_q  <= tscc_pkg::RST_OFFSET;
            shot_q  <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            model_q <= model_d;
            standby_control_q  <= standby_control_d;
            rate_q  <= rate_d;
            chen_q  <= chen_d;
            off1_q  <= off1_d;
            off2_q  <= off2_d;
            shot_q  <= shot_d;
            rdata_q <= rdata_d;
        end
    end

    // Millisecond enable for interval padding
    tscc_tick_div #(
        .DIV (CYC_PER_TICK)
    ) u_tick (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_clear   (seq_begin),
        .o_tick    (tick)
    );

    // Interval length in ticks for the selected code
    logic [TW-1:0] interval_ms;
    always_comb begin
        case (rate_q)
            tscc_pkg::RATE_364: interval_ms = TW'(tscc_pkg::INTERVAL_364_MS); // [RULE5]
            tscc_pkg::RATE_1S:  interval_ms = TW'(tscc_pkg::INTERVAL_1S_MS);
            tscc_pkg::RATE_2S5: interval_ms = TW'(tscc_pkg::INTERVAL_2S5_MS);
            default:            interval_ms = '0;
        endcase
    end

    // First enabled channel at or after the current one
    logic       next_ok;
    logic [1:0] next_chan;
    always_comb begin
        next_ok   = 1'b0;
        next_chan = chan_q;
        for (int i = 2; i >= 0; i--) begin
            if (chen_q[i] && 2'(i) >= chan_q) begin // [RULE7]
                next_ok   = 1'b1;
                next_chan = 2'(i);
            end
        end
    end

    assign seq_begin = (st_q == tscc_pkg::SEQ_IDLE) && (!standby_control_q || shot_q); // [RULE4] [RULE11]

    // Sequencer: a running sequence always finishes even if standby is set
    always_comb begin
        st_d    = st_q;
        chan_d  = chan_q;
        start_d = 1'b0;
        ms_d    = ms_q;
        if (seq_begin) begin
            ms_d = '0;
        end else if (tick && ms_q != '1) begin
            ms_d = ms_q + TW'(1);
        end
        case (st_q)
            tscc_pkg::SEQ_IDLE: begin
                if (seq_begin) begin
                    st_d   = tscc_pkg::SEQ_PICK;
                    chan_d = tscc_pkg::CHAN_LOCAL;
                end
            end
            tscc_pkg::SEQ_PICK: begin
                if (next_ok) begin
                    st_d    = tscc_pkg::SEQ_CONV; // [RULE6]
                    chan_d  = next_chan;
                    start_d = 1'b1;
                end else begin
                    st_d = tscc_pkg::SEQ_PAD;
                end
            end
            tscc_pkg::SEQ_CONV: begin
                if (i_conv_done) begin
                    if (chan_q == tscc_pkg::CHAN_R2) begin
                        st_d = tscc_pkg::SEQ_PAD;
                    end else begin
                        st_d   = tscc_pkg::SEQ_PICK;
                        chan_d = chan_q + 2'h1;
                    end
                end
            end
            tscc_pkg::SEQ_PAD: begin
                // Padding is fixed by elapsed time, so skipped channels
                // lengthen the pad and only continuous mode runs faster
                if (standby_control_q || ms_q >= interval_ms) begin // [RULE6] [RULE8]
                    st_d = tscc_pkg::SEQ_IDLE;
                end
            end
            default: st_d = tscc_pkg::SEQ_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            st_q    <= tscc_pkg::SEQ_IDLE;
            chan_q  <= tscc_pkg::CHAN_LOCAL;
            ms_q    <= '0;
            start_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            chan_q  <= chan_d;
            ms_q    <= ms_d;
            start_q <= start_d;
        end
    end

    // Offset correction: half-degree offset scaled to eighth-degree raw, saturated
    logic signed [12:0] sum;
    logic [7:0]         off_sel;
    always_comb begin
        off_sel = (chan_q == tscc_pkg::CHAN_R1) ? off1_q : off2_q;
        sum     = $signed({{2{i_conv_raw[10]}}, i_conv_raw});
        if (chan_q != tscc_pkg::CHAN_LOCAL) begin
            sum = sum + $signed({{3{off_sel[7]}}, off_sel, 2'b00}); // [RULE3]
        end
        tv_d   = 1'b0;
        tc_d   = tc_q;
        tval_d = tval_q;
        if (st_q == tscc_pkg::SEQ_CONV && i_conv_done) begin
            tv_d = 1'b1;
            tc_d = chan_q;
            if (sum > 13'sd1023) begin
                tval_d = 11'h3ff;
            end else if (sum < -13'sd1024) begin
                tval_d = 11'h400;
            end else begin
                tval_d = sum[10:0];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            tv_q   <= 1'b0;
            tc_q   <= tscc_pkg::CHAN_LOCAL;
            tval_q <= 11'h000;
        end else begin
            tv_q   <= tv_d;
            tc_q   <= tc_d;
            tval_q <= tval_d;
        end
    end

    assign o_rdata      = rdata_q;
    assign o_conv_start = start_q;
    assign o_conv_chan  = chan_q;
    assign o_model_sel  = (chan_q == tscc_pkg::CHAN_R1) ? model_q[0] :
                          (chan_q == tscc_pkg::CHAN_R2) ? model_q[1] : 1'b0; // [RULE1]
    assign o_temp_valid = tv_q;
    assign o_temp_chan  = tc_q;
    assign o_temp_value = tval_q;
    assign o_busy       = (st_q == tscc_pkg::SEQ_PICK) || (st_q == tscc_pkg::SEQ_CONV); // [RULE12]

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence shot_in_standby_s;
        i_wr_en && i_cmd == tscc_pkg::CMD_ONE_SHOT && standby_control_q && st_q == tscc_pkg::SEQ_IDLE;
    endsequence
    sequence first_start_s;
        ##[1:3] o_conv_start;
    endsequence

    // Enable mask as it stood when the channel was picked; a later write may clear it
    start_enabled_a: assert property (o_conv_start |-> (($past(chen_q) >> o_conv_chan) & 3'h1) != 3'h0) // [RULE7]
        else $error("conversion started on a disabled channel");
    start_busy_a: assert property (o_conv_start |-> o_busy) // [RULE12]
        else $error("busy low during conversion");
    model_drive_a: assert property (o_conv_start && o_conv_chan == tscc_pkg::CHAN_R2
        |-> o_model_sel == model_q[1]) // [RULE1]
        else $error("wrong diode model for remote two");
    oneshot_run_a: assert property (shot_in_standby_s ##0 (chen_q != 3'h0)
        |-> first_start_s) // [RULE11]
        else $error("one-shot did not start a conversion");
    standby_quiet_a: assert property (standby_control_q && !shot_q && st_q == tscc_pkg::SEQ_IDLE
        && !i_wr_en |=> st_q == tscc_pkg::SEQ_IDLE) // [RULE4]
        else $error("sequence began while in standby");
    pad_hold_a: assert property (st_q == tscc_pkg::SEQ_PAD && !standby_control_q
        && ms_q < interval_ms |=> st_q == tscc_pkg::SEQ_PAD) // [RULE8]
        else $error("interval padding ended early");
    reserved_read_a: assert property (i_rd_en && i_cmd == tscc_pkg::CMD_DIODE
        |=> o_rdata[7:3] == 5'h00 && o_rdata[0] == 1'b0) // [RULE10]
        else $error("reserved diode model bits read nonzero");
    offset_sum_a: assert property (st_q == tscc_pkg::SEQ_CONV && i_conv_done
        && chan_q == tscc_pkg::CHAN_R1 && off1_q == 8'h7f && i_conv_raw == 11'h3f1
        |=> o_temp_valid && o_temp_value == 11'h3ff) // [RULE3]
        else $error("remote one offset not applied");
    rate_write_a: assert property (i_wr_en && i_cmd == tscc_pkg::CMD_RATE
        |=> rate_q == $past(i_wdata[1:0])) // [RULE13]
        else $error("rate field write lost");
endmodule // tscc_conv_config

// ==== tscc_pkg.sv ====
// Shared constants for the temperature sensor conversion configuration block
package tscc_pkg;
    // Command byte addresses
    localparam logic [7:0] CMD_STATUS   = 8'h02;
    localparam logic [7:0] CMD_CONFIG   = 8'h03;
    localparam logic [7:0] CMD_RATE     = 8'h04;
    localparam logic [7:0] CMD_CHAN_EN  = 8'h05;
    localparam logic [7:0] CMD_ONE_SHOT = 8'h0f;
    localparam logic [7:0] CMD_DIODE    = 8'h30;
    localparam logic [7:0] CMD_OFF_ONE  = 8'h31;
    localparam logic [7:0] CMD_OFF_TWO  = 8'h32;

    // Field positions
    localparam int STANDBY_BIT = 6;
    localparam int R1_MODEL_BIT = 1;
    localparam int R2_MODEL_BIT = 2;
    localparam int LOCAL_EN_BIT = 0;
    localparam int R1_EN_BIT    = 1;
    localparam int R2_EN_BIT    = 2;
    localparam int BUSY_BIT     = 7;

    // Reset values
    localparam logic [7:0] RST_CONFIG  = 8'h00;
    localparam logic [7:0] RST_RATE    = 8'h02;
    localparam logic [7:0] RST_CHAN_EN = 8'h1f;
    localparam logic [7:0] RST_DIODE   = 8'h02;
    localparam logic [7:0] RST_OFFSET  = 8'h00;

    // Conversion rate codes
    localparam logic [1:0] RATE_CONT = 2'h0;
    localparam logic [1:0] RATE_364  = 2'h1;
    localparam logic [1:0] RATE_1S   = 2'h2;
    localparam logic [1:0] RATE_2S5  = 2'h3;

    // Timing: the interval is counted in millisecond ticks
    localparam int CLK_PERIOD_PS = 10000;
    localparam int TICK_PERIOD_PS = 1000000000;
    localparam int CYC_PER_TICK = TICK_PERIOD_PS / CLK_PERIOD_PS;
    localparam int INTERVAL_364_MS = 364;
    localparam int INTERVAL_1S_MS  = 1000;
    localparam int INTERVAL_2S5_MS = 2500;
    localparam int TICK_W = 12;

    // Channel numbering in sequencing order
    localparam logic [1:0] CHAN_LOCAL = 2'h0;
    localparam logic [1:0] CHAN_R1    = 2'h1;
    localparam logic [1:0] CHAN_R2    = 2'h2;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_PICK,
        SEQ_CONV,
        SEQ_PAD
    } tscc_seq_type;
endpackage

// ==== tscc_tick_div.sv ====
// Clock divider giving a one-cycle enable pulse every DIV cycles
module tscc_tick_div #(
    parameter int DIV = 100000
) (
    input  wire logic i_ref_clk,
    input  wire logic i_rst_n,
    input  wire logic i_clear,
    output logic      o_tick
);
    localparam int CW = $clog2(DIV);

    initial begin
        if (DIV < 2) begin
            $error("tscc_tick_div: DIV must be at least 2");
        end
    end

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;

    // Wrap at DIV-1; clear realigns the phase to a new sequence
    always_comb begin
        if (i_clear || cnt_q == CW'(DIV - 1)) begin
            cnt_d = '0;
        end else begin
            cnt_d = cnt_q + CW'(1);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign o_tick = !i_clear && (cnt_q == CW'(DIV - 1));
endmodule // tscc_tick_div

// ==== tscc_adc_model.sv ====
// ADC stand-in that answers each conversion start after a fixed delay
module tscc_adc_model #(
    parameter int DLY = 20
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_start,
    input  wire logic [1:0]  i_chan,
    output logic             o_done,
    output logic      [10:0] o_raw
);
    timeunit 1ns;
    timeprecision 1ps;
    int          cnt = 0;
    logic [10:0] val = 11'h000;
    // Raw value marks the channel; the bus shows the inverse when idle
    // so a late sample of stale data cannot pass for a result
    always @(posedge i_ref_clk) begin
        o_done <= 1'b0;
        o_raw  <= ~val;
        if (i_start) begin
            cnt <= DLY;
            val <= 11'h3f0 + 11'(i_chan);
        end else if (cnt == 1) begin
            cnt    <= 0;
            o_done <= 1'b1;
            o_raw  <= val;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule // tscc_adc_model

// ==== tscc_conv_config_tb.sv ====
// Self-checking bench for the conversion configuration block
module tscc_conv_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CPT = 4;
    logic        i_ref_clk = 1'b0;
    logic        i_rst_n   = 1'b0;
    logic        i_wr_en   = 1'b0;
    logic        i_rd_en   = 1'b0;
    logic [7:0]  i_cmd     = 8'h00;
    logic [7:0]  i_wdata   = 8'h00;
    logic [7:0]  o_rdata;
    logic        o_conv_start;
    logic [1:0]  o_conv_chan;
    logic        o_model_sel;
    logic        conv_done;
    logic [10:0] conv_raw;
    logic        o_temp_valid;
    logic [1:0]  o_temp_chan;
    logic [10:0] o_temp_value;
    logic        o_busy;
    int          bad_count   = 0;
    int          check_count = 0;
    logic [12:0] res_q[$];
    logic        sel_q[$];

    always #5 i_ref_clk = ~i_ref_clk;

    tscc_conv_config #(.CYC_PER_TICK(CPT)) i_dut (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_wr_en(i_wr_en),
        .i_rd_en(i_rd_en), .i_cmd(i_cmd), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .o_conv_start(o_conv_start), .o_conv_chan(o_conv_chan),
        .o_model_sel(o_model_sel), .i_conv_done(conv_done), .i_conv_raw(conv_raw),
        .o_temp_valid(o_temp_valid), .o_temp_chan(o_temp_chan),
        .o_temp_value(o_temp_value), .o_busy(o_busy));

    tscc_adc_model i_adc (.i_ref_clk(i_ref_clk), .i_start(o_conv_start),
        .i_chan(o_conv_chan), .o_done(conv_done), .o_raw(conv_raw));

    // Results and model choices are logged between edges, clear of races
    always @(negedge i_ref_clk) begin
        if (o_conv_start === 1'b1) sel_q.push_back(o_model_sel);
        if (o_temp_valid === 1'b1) res_q.push_back({o_temp_chan, o_temp_value});
    end

    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", bad_count, check_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk_val(logic [15:0] got, logic [15:0] exp, string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_cond(bit ok, string what);
        check_count++;
        if (!ok) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic wr(logic [7:0] c, logic [7:0] v);
        @(posedge i_ref_clk);
        i_wr_en <= 1'b1;
        i_cmd   <= c;
        i_wdata <= v;
        @(posedge i_ref_clk);
        i_wr_en <= 1'b0;
    endtask

    // Read data is held until the next read, so one spare cycle is safe
    task automatic rchk(logic [7:0] c, logic [7:0] exp);
        @(posedge i_ref_clk);
        i_rd_en <= 1'b1;
        i_cmd   <= c;
        @(posedge i_ref_clk);
        i_rd_en <= 1'b0;
        @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        chk_val({8'h00, o_rdata}, {8'h00, exp}, "register read");
    endtask

    // Every wait is bounded; running out ends the run as a failure
    task automatic wait_busy(logic want);
        int n;
        for (n = 0; n < 20000 && o_busy !== want; n++) @(negedge i_ref_clk);
        chk_cond(o_busy === want, "busy wait timed out");
        if (o_busy !== want) close_out();
    endtask

    task automatic next_local(inout int t);
        int n;
        for (n = 0; n < 12000; n++) begin
            @(negedge i_ref_clk);
            t++;
            if (o_conv_start === 1'b1 && o_conv_chan === 2'h0) break;
        end
        if (n == 12000) begin
            chk_cond(1'b0, "no local conversion start");
            close_out();
        end
    endtask

    // Period from the second to the third local start; the first interval is left to settle
    task automatic period(output int p);
        int t;
        t = 0;
        next_local(t);
        next_local(t);
        p = 0;
        next_local(p);
    endtask

    function automatic logic [10:0] fix(int raw, int off);
        int s;
        s = raw + off * 4;
        if (s > 1023) s = 1023;
        if (s < -1024) s = -1024;
        return 11'(s);
    endfunction

    task automatic t_reset();
        logic [7:0] cmds[7] = '{8'h03, 8'h04, 8'h05, 8'h30, 8'h31, 8'h32, 8'h40};
        logic [7:0] exps[7] = '{8'h00, 8'h02, 8'h07, 8'h02, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 7; i++) rchk(cmds[i], exps[i]);
    endtask

    // All ones everywhere: only the stored fields may come back
    task automatic t_write_ones();
        logic [7:0] cmds[7] = '{8'h03, 8'h04, 8'h05, 8'h30, 8'h31, 8'h32, 8'h40};
        logic [7:0] exps[7] = '{8'h40, 8'h03, 8'h07, 8'h06, 8'hff, 8'hff, 8'h00};
        for (int i = 0; i < 7; i++) wr(cmds[i], 8'hff);
        for (int i = 0; i < 7; i++) rchk(cmds[i], exps[i]);
    endtask

    // One-shot in standby, local skipped, offsets at both range ends
    task automatic t_one_shot();
        wr(8'h04, 8'h00);
        wait_busy(1'b0);
        wr(8'h05, 8'h06);
        wr(8'h30, 8'h04);
        wr(8'h31, 8'h7f);
        wr(8'h32, 8'h80);
        res_q.delete();
        sel_q.delete();
        wr(8'h0f, 8'ha5);
        wait_busy(1'b1);
        rchk(8'h02, 8'h80);
        wait_busy(1'b0);
        rchk(8'h02, 8'h00);
        repeat (400) @(negedge i_ref_clk);
        chk_val(16'(res_q.size()), 16'h0002, "result count in standby");
        chk_val({3'h0, res_q[0]}, {5'h01, fix(11'h3f1, 127)}, "first result");
        chk_val({3'h0, res_q[1]}, {5'h02, fix(11'h3f2, -128)}, "second result");
        chk_val({14'h0, sel_q[0], sel_q[1]}, 16'h0001, "model choices");
    endtask

    // Padded rates keep the interval; continuous shrinks with fewer channels
    task automatic t_rates();
        int ms[4] = '{0, 364, 1000, 2500};
        int p;
        int pa;
        wr(8'h03, 8'h00);
        wr(8'h05, 8'h01);
        for (int c = 1; c < 4; c++) begin
            wr(8'h04, 8'(c));
            period(p);
            chk_cond(p >= ms[c] * CPT - 2 * CPT && p <= ms[c] * CPT + 2 * CPT,
                     "padded interval");
        end
        wr(8'h04, 8'h00);
        wr(8'h05, 8'h07);
        period(pa);
        chk_cond(pa < ms[1] * CPT, "continuous faster than 364 ms");
        wr(8'h05, 8'h01);
        period(p);
        chk_cond(p < pa, "continuous period shortens");
    endtask

    initial begin
        repeat (16) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_write_ones();
        t_one_shot();
        t_rates();
        close_out();
    end
endmodule // tscc_conv_config_tb
